// >>> hw/flash_seq_defs.svh
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// ************************************************************
// Clock and programming time
// ************************************************************
`define CLK_PERIOD_NS 10
`define PROG_TIME_NS 20000
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)

// ************************************************************
// Unlock key values
// ************************************************************
`define KEY_CODE_FIRST 8'hA5
`define KEY_CODE_SECOND 8'hF1

// ************************************************************
// Field positions inside the device registers
// ************************************************************
`define PSCR_WRITE_EN_BIT 0
`define PSCR_ERASE_EN_BIT 1
`define CACHE_BLOCK_EN_BIT 0

// ************************************************************
// Host command port offsets and fields
// ************************************************************
`define HOST_REG_ADDR_LO 4'h0
`define HOST_REG_ADDR_HI 4'h1
`define HOST_REG_DATA 4'h2
`define HOST_REG_CMD 4'h3
`define HOST_REG_STATUS 4'h4
`define HOST_RESET_BYTE 8'h00

`endif

// >>> hw/flash_seq_pkg.sv
package flash_seq_pkg;

  // Kind of access the core puts on the link
  typedef enum logic [1:0]
  {
    OP_CTRL = 2'b00,
    OP_KEY = 2'b01,
    OP_CACHE = 2'b10,
    OP_MOVE = 2'b11
  } link_op_t;

  // Progress through the two-value unlock
  typedef enum logic [1:0]
  {
    KEY_IDLE = 2'b00,
    KEY_HALF = 2'b01,
    KEY_OPEN = 2'b10
  } key_state_t;

endpackage

// >>> hw/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if #(parameter int ADDR_W = 14);
  import flash_seq_pkg::*;
  logic req_wr;
  link_op_t req_kind;
  logic [ADDR_W-1:0] req_addr;
  logic [7:0] req_data;
  logic busy;
  logic [2:0] ctrl_bits;

  modport dev
  (
    input req_wr,
    input req_kind,
    input req_addr,
    input req_data,
    output busy,
    output ctrl_bits
  );

  modport host
  (
    output req_wr,
    output req_kind,
    output req_addr,
    output req_data,
    input busy,
    input ctrl_bits
  );
endinterface

// >>> hw/flash_core_end.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_core_end #(
  parameter int ADDR_W = 14
)
(
  input wire logic MCLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic CE, // Clock enable
  input wire logic [3:0] ADDR, // Command port address
  input wire logic [7:0] WDATA, // Command port write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [7:0] RDATA, // Read data, cycle after RD
  flash_link_if.host LINK // Link to the sequencer
);
  import flash_seq_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
    link_op_t kind;
    logic pend;
    logic [7:0] rdata;
    logic req_wr;
    link_op_t req_kind;
    logic [ADDR_W-1:0] req_addr;
    logic [7:0] req_data;
  } core_state_t;

  core_state_t st_ff;
  core_state_t nxt_st;

  if (ADDR_W < 9 || ADDR_W > 16)
  begin : g_bad_width
    $error("ADDR_W must lie between 9 and 16");
  end

  // Register writes, queued request and read mux
  always_comb
  begin
    logic [15:0] full_addr;
    full_addr = {st_ff.addr_hi, st_ff.addr_lo};
    nxt_st = st_ff;
    nxt_st.req_wr = 1'b0;
    nxt_st.rdata = `HOST_RESET_BYTE;
    // A fire is followed by one dead cycle so the device busy flag is seen
    if (st_ff.pend && !LINK.busy && !st_ff.req_wr)
    begin
      nxt_st.req_wr = 1'b1;
      nxt_st.req_kind = st_ff.kind;
      nxt_st.req_addr = full_addr[ADDR_W-1:0];
      nxt_st.req_data = st_ff.data;
      nxt_st.pend = 1'b0;
    end
    if (WR)
    begin
      unique case (ADDR)
        `HOST_REG_ADDR_LO: nxt_st.addr_lo = WDATA;
        `HOST_REG_ADDR_HI: nxt_st.addr_hi = WDATA;
        `HOST_REG_DATA: nxt_st.data = WDATA;
        `HOST_REG_CMD:
        begin
          // A command written while one is queued is dropped
          if (!st_ff.pend)
          begin
            nxt_st.kind = link_op_t'(WDATA[1:0]);
            nxt_st.pend = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (RD)
    begin
      unique case (ADDR)
        `HOST_REG_ADDR_LO: nxt_st.rdata = st_ff.addr_lo;
        `HOST_REG_ADDR_HI: nxt_st.rdata = st_ff.addr_hi;
        `HOST_REG_DATA: nxt_st.rdata = st_ff.data;
        `HOST_REG_CMD: nxt_st.rdata = {6'h00, st_ff.kind};
        `HOST_REG_STATUS: nxt_st.rdata = {3'h0, LINK.ctrl_bits, LINK.busy, st_ff.pend};
        default: nxt_st.rdata = `HOST_RESET_BYTE;
      endcase
    end
  end

  // State register
  always_ff @(posedge MCLK)
  begin
    if (RST)
      st_ff <= '0;
    else if (CE)
      st_ff <= nxt_st;
  end

  assign RDATA = st_ff.rdata;
  assign LINK.req_wr = st_ff.req_wr;
  assign LINK.req_kind = st_ff.req_kind;
  assign LINK.req_addr = st_ff.req_addr;
  assign LINK.req_data = st_ff.req_data;
endmodule

// >>> hw/flash_seq_end.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_seq_end #(
  parameter int ADDR_W = 14,
  parameter int PROG_CYC = `PROG_CYCLES
)
(
  input wire logic MCLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic CE, // Clock enable
  flash_link_if.dev LINK, // Requests from the core
  output logic FLASH_WR, // One-cycle program pulse
  output logic FLASH_PAIR, // Pulse carries two bytes
  output logic [ADDR_W-1:0] FLASH_ADDR, // First byte address
  output logic [15:0] FLASH_DATA, // High byte second, low first
  output logic XRAM_WR, // One-cycle data memory write
  output logic [ADDR_W-1:0] XRAM_ADDR, // Data memory address
  output logic [7:0] XRAM_DATA, // Data memory byte
  output logic BUSY, // Programming in progress
  output logic UNLOCKED // Key pair complete, not yet used
);
  import flash_seq_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic write_en;
    logic erase_en;
    logic block_en;
    key_state_t key;
    logic unlocked;
    logic cache_valid;
    logic [ADDR_W-1:0] cache_addr;
    logic [7:0] cache_data;
    logic busy;
    logic [15:0] cnt;
    logic fwr;
    logic fpair;
    logic [ADDR_W-1:0] faddr;
    logic [15:0] fdata;
    logic xwr;
    logic [ADDR_W-1:0] xaddr;
    logic [7:0] xdata;
  } seq_state_t;

  seq_state_t st_ff;
  seq_state_t nxt_st;

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (PROG_CYC < 1 || PROG_CYC > 65535)
  begin : g_bad_prog
    $error("PROG_CYC must lie between 1 and 65535");
  end
  if (ADDR_W < 9 || ADDR_W > 16)
  begin : g_bad_width
    $error("ADDR_W must lie between 9 and 16");
  end

  localparam logic [15:0] PROG_LOAD = 16'(PROG_CYC);

  // Next state: countdown, register writes, key walk, data moves
  always_comb
  begin
    logic [ADDR_W-1:0] next_addr;
    logic [7:0] kval;
    next_addr = st_ff.cache_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
    kval = LINK.req_data;
    nxt_st = st_ff;
    nxt_st.fwr = 1'b0;
    nxt_st.xwr = 1'b0;
    // Programming time runs down; single and pair load the same count
    if (st_ff.busy)
    begin
      if (st_ff.cnt == 16'h0001)
      begin
        nxt_st.busy = 1'b0;
        nxt_st.cnt = 16'h0000;
      end
      else
        nxt_st.cnt = st_ff.cnt - 16'h0001;
    end
    if (LINK.req_wr)
    begin
      unique case (LINK.req_kind)
        OP_CTRL:
        begin
          // Firmware ordering of these bits is its own business
          nxt_st.write_en = kval[`PSCR_WRITE_EN_BIT];
          nxt_st.erase_en = kval[`PSCR_ERASE_EN_BIT];
        end
        OP_CACHE:
        begin
          nxt_st.block_en = kval[`CACHE_BLOCK_EN_BIT];
          // Leaving block mode throws away an uncommitted byte
          if (!kval[`CACHE_BLOCK_EN_BIT])
            nxt_st.cache_valid = 1'b0;
        end
        OP_KEY:
        begin
          // Keys written during programming are dropped outright
          if (!st_ff.busy)
          begin
            unique case (st_ff.key)
              KEY_IDLE:
                nxt_st.key = (kval == `KEY_CODE_FIRST) ? KEY_HALF : KEY_IDLE;
              KEY_HALF:
                nxt_st.key = (kval == `KEY_CODE_SECOND) ? KEY_OPEN : KEY_IDLE;
              KEY_OPEN:
                nxt_st.key = (kval == `KEY_CODE_FIRST) ? KEY_HALF : KEY_IDLE;
              default:
                nxt_st.key = KEY_IDLE;
            endcase
          end
        end
        OP_MOVE:
        begin
          if (!st_ff.write_en)
          begin
            // Write enable clear: the move goes to data memory
            nxt_st.xwr = 1'b1;
            nxt_st.xaddr = LINK.req_addr;
            nxt_st.xdata = kval;
          end
          else if (!st_ff.busy)
          begin
            // A move to program memory made while not busy uses up a full or partial unlock
            nxt_st.key = KEY_IDLE;
            if (st_ff.key == KEY_OPEN && !st_ff.erase_en)
            begin
              if (!st_ff.block_en)
              begin
                nxt_st.fwr = 1'b1;
                nxt_st.fpair = 1'b0;
                nxt_st.faddr = LINK.req_addr;
                nxt_st.fdata = {8'h00, kval};
                nxt_st.busy = 1'b1;
                nxt_st.cnt = PROG_LOAD;
              end
              else if (st_ff.cache_valid && LINK.req_addr == next_addr)
              begin
                nxt_st.fwr = 1'b1;
                nxt_st.fpair = 1'b1;
                nxt_st.faddr = st_ff.cache_addr;
                nxt_st.fdata = {kval, st_ff.cache_data};
                nxt_st.busy = 1'b1;
                nxt_st.cnt = PROG_LOAD;
                nxt_st.cache_valid = 1'b0;
              end
              else
              begin
                // A non-adjacent byte replaces the cached one, which is lost
                nxt_st.cache_valid = 1'b1;
                nxt_st.cache_addr = LINK.req_addr;
                nxt_st.cache_data = kval;
              end
            end
          end
        end
        default: ;
      endcase
    end
    // Registered copy of the open key state, so the pin carries no decode logic
    nxt_st.unlocked = (nxt_st.key == KEY_OPEN);
  end

  // State register; CE low freezes everything including the countdown
  always_ff @(posedge MCLK)
  begin
    if (RST)
      st_ff <= '0;
    else if (CE)
      st_ff <= nxt_st;
  end

  // ************************************************************
  // Outputs, all taken from the state register
  // ************************************************************
  assign FLASH_WR = st_ff.fwr;
  assign FLASH_PAIR = st_ff.fpair;
  assign FLASH_ADDR = st_ff.faddr;
  assign FLASH_DATA = st_ff.fdata;
  assign XRAM_WR = st_ff.xwr;
  assign XRAM_ADDR = st_ff.xaddr;
  assign XRAM_DATA = st_ff.xdata;
  assign BUSY = st_ff.busy;
  assign UNLOCKED = st_ff.unlocked;
  assign LINK.busy = st_ff.busy;
  assign LINK.ctrl_bits = {st_ff.block_en, st_ff.erase_en, st_ff.write_en};
endmodule

// >>> testbench/flash_link_checker.sv
`timescale 1ns/1ps
module flash_link_checker #(
  parameter int PROG_CYC = 5
)
(
  input wire logic MCLK, // System clock
  input wire logic RST, // Synchronous reset
  input wire logic req_wr, // Request valid
  input wire flash_seq_pkg::link_op_t req_kind, // Request kind
  input wire logic [7:0] req_data, // Request value
  input wire logic busy, // Programming in progress
  input wire logic [2:0] ctrl_bits // Block, erase, write enables
);
  import flash_seq_pkg::*;
  int busy_len_ff;

  // Busy cycles so far; a plain repetition cannot follow the parameter
  always_ff @(posedge MCLK)
  begin
    if (RST || !busy)
      busy_len_ff <= 0;
    else
      busy_len_ff <= busy_len_ff + 1;
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // Steps of one unlocked single-byte program memory move
  sequence s_key_first;
    req_wr && req_kind == OP_KEY && req_data == 8'hA5;
  endsequence
  sequence s_key_second;
    req_wr && req_kind == OP_KEY && req_data == 8'hF1;
  endsequence
  sequence s_single_move;
    req_wr && req_kind == OP_MOVE && ctrl_bits == 3'b001 && !busy;
  endsequence

  a_unlocked_move: assert property (s_key_first ##[2:8] s_key_second ##[2:8] s_single_move |=> busy)
    else $error("unlocked move did not start programming");
  a_busy_cause: assert property ($rose(busy) |-> $past(req_wr) && $past(req_kind) == OP_MOVE &&
    $past(ctrl_bits[1:0]) == 2'b01)
    else $error("busy rose without an enabled move");
  a_busy_length: assert property ($fell(busy) |-> busy_len_ff == PROG_CYC)
    else $error("programming time wrong");
  a_busy_bound: assert property (busy_len_ff <= PROG_CYC)
    else $error("busy held too long");
  a_data_move: assert property (req_wr && req_kind == OP_MOVE && !ctrl_bits[0] |=> !busy)
    else $error("data memory move started programming");
  a_ctrl_write: assert property (req_wr && req_kind == OP_CTRL |=> ctrl_bits[1:0] == $past(req_data[1:0]))
    else $error("control write not taken");
  a_cache_write: assert property (req_wr && req_kind == OP_CACHE |=> ctrl_bits[2] == $past(req_data[0]))
    else $error("block enable write not taken");
  a_ctrl_hold: assert property (!(req_wr && req_kind inside {OP_CTRL, OP_CACHE}) |=> $stable(ctrl_bits))
    else $error("enables changed without a write");
  a_host_wait: assert property (req_wr |-> !busy ##1 !req_wr)
    else $error("request while busy or back to back");
endmodule

// >>> testbench/flash_byte_write_sequencer_tb_top.sv
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_byte_write_sequencer_tb_top;
  import flash_seq_pkg::*;
  localparam int PROG = 5;
  logic mclk, rst, wr, rd, flash_wr, flash_pair, xram_wr, busy, fp, unlocked;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, xram_data, xd, r;
  logic [13:0] flash_addr, xram_addr, fa, xa;
  logic [15:0] flash_data, fd;
  int fail_count, check_count, flash_n, xram_n, busy_run, cyc, n0;

  flash_link_if #(.ADDR_W(14)) link();
  flash_core_end #(.ADDR_W(14)) i_flash_core_end(.MCLK(mclk), .RST(rst), .CE(1'b1), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link.host));
  flash_seq_end #(.ADDR_W(14), .PROG_CYC(PROG)) i_flash_seq_end(.MCLK(mclk), .RST(rst), .CE(1'b1),
    .LINK(link.dev), .FLASH_WR(flash_wr), .FLASH_PAIR(flash_pair), .FLASH_ADDR(flash_addr),
    .FLASH_DATA(flash_data), .XRAM_WR(xram_wr), .XRAM_ADDR(xram_addr), .XRAM_DATA(xram_data),
    .BUSY(busy), .UNLOCKED(unlocked));
  flash_link_checker #(.PROG_CYC(PROG)) i_flash_link_checker(.MCLK(mclk), .RST(rst), .req_wr(link.req_wr),
    .req_kind(link.req_kind), .req_data(link.req_data), .busy(link.busy), .ctrl_bits(link.ctrl_bits));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Record array and data memory pulses; also cuts a hang short
  always @(posedge mclk)
  begin
    cyc++;
    if (busy)
      busy_run++;
    if (flash_wr)
    begin
      flash_n++;
      fa = flash_addr;
      fd = flash_data;
      fp = flash_pair;
    end
    if (xram_wr)
    begin
      xram_n++;
      xa = xram_addr;
      xd = xram_data;
    end
    if (cyc == 3000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Bus tasks
  // ************************************************************
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
  endtask

  // Requests land at least eight cycles apart; the spare edge lets the recorder count a pulse before any check
  task automatic cmd(input link_op_t k, input logic [7:0] d, input logic [13:0] a = 14'h0000);
    wreg(`HOST_REG_ADDR_LO, a[7:0]);
    wreg(`HOST_REG_ADDR_HI, {2'b00, a[13:8]});
    wreg(`HOST_REG_DATA, d);
    wreg(`HOST_REG_CMD, {6'h00, k});
    wr <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 20 && busy; i++)
      @(posedge mclk);
  endtask

  task automatic key_move(input logic [7:0] d, input logic [13:0] a);
    cmd(OP_KEY, 8'hA5);
    cmd(OP_KEY, 8'hF1);
    cmd(OP_MOVE, d, a);
  endtask

  task automatic read_status();
    rd <= 1'b1;
    addr <= `HOST_REG_STATUS;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    r = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Everything idle and locked straight after reset
  task automatic t_reset();
    read_status();
    chk({8'h00, r}, 16'h0000);
    chk({15'h0000, unlocked}, 16'h0000);
  endtask

  // The target page counts as erased already; erase itself is not modelled
  task automatic t_single();
    cmd(OP_CTRL, 8'h01);
    read_status();
    chk({8'h00, r}, 16'h0004);
    n0 = flash_n;
    busy_run = 0;
    cmd(OP_KEY, 8'hA5);
    chk({15'h0000, unlocked}, 16'h0000);
    cmd(OP_KEY, 8'hF1);
    chk({15'h0000, unlocked}, 16'h0001);
    cmd(OP_MOVE, 8'h5A, 14'h0123);
    chk({15'h0000, unlocked}, 16'h0000);
    chk(16'(flash_n - n0), 16'h0001);
    chk({2'b00, fa}, 16'h0123);
    chk(fd, 16'h005A);
    chk({15'h0000, fp}, 16'h0000);
    chk(16'(busy_run), 16'(PROG));
  endtask

  // Moves without a clean key pair, and a second move on a spent unlock
  task automatic t_reject();
    n0 = flash_n;
    cmd(OP_MOVE, 8'h66, 14'h0010);
    chk(16'(flash_n - n0), 16'h0000);
    cmd(OP_KEY, 8'hA5);
    cmd(OP_KEY, 8'h11);
    cmd(OP_KEY, 8'hF1);
    cmd(OP_MOVE, 8'h67, 14'h0011);
    chk(16'(flash_n - n0), 16'h0000);
    key_move(8'h68, 14'h0012);
    cmd(OP_MOVE, 8'h69, 14'h0013);
    chk(16'(flash_n - n0), 16'h0001);
  endtask

  task automatic t_block();
    cmd(OP_CACHE, 8'h01);
    cmd(OP_CTRL, 8'h01);
    n0 = flash_n;
    key_move(8'h11, 14'h0200);
    chk(16'(flash_n - n0), 16'h0000);
    busy_run = 0;
    key_move(8'h22, 14'h0201);
    chk(16'(flash_n - n0), 16'h0001);
    chk({15'h0000, fp}, 16'h0001);
    chk({2'b00, fa}, 16'h0200);
    chk(fd, 16'h2211);
    chk(16'(busy_run), 16'(PROG));
    key_move(8'h33, 14'h0300);
    cmd(OP_CTRL, 8'h00);
    cmd(OP_CACHE, 8'h00);
    chk(16'(flash_n - n0), 16'h0001);
    // Back in block mode the dropped byte must not pair with its neighbour
    cmd(OP_CACHE, 8'h01);
    cmd(OP_CTRL, 8'h01);
    key_move(8'h44, 14'h0301);
    chk(16'(flash_n - n0), 16'h0001);
    cmd(OP_CTRL, 8'h00);
    cmd(OP_CACHE, 8'h00);
  endtask

  task automatic t_steer();
    n0 = xram_n;
    cmd(OP_MOVE, 8'h77, 14'h0045);
    chk(16'(xram_n - n0), 16'h0001);
    chk({2'b00, xa}, 16'h0045);
    chk({8'h00, xd}, 16'h0077);
    n0 = flash_n;
    cmd(OP_CTRL, 8'h03);
    read_status();
    chk({8'h00, r}, 16'h000C);
    key_move(8'h44, 14'h0050);
    chk(16'(flash_n - n0), 16'h0000);
  endtask

  initial
  begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_single();
    t_reject();
    t_block();
    t_steer();
    wrap_up();
  end
endmodule
